// ==== bench/instruction_word_decoder_tb_top.sv ====
// Self-checking testbench of the instruction word decoder.
`timescale 1ns/10ps
module instruction_word_decoder_tb_top;
	import iwd_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        fetch_valid;
	logic [23:0] fetch_word;
	logic        dec_valid_ff;
	iwd_cat_e    dec_cat_ff;
	logic [7:0]  dec_opcode_ff;
	logic        dec_nop_ff;
	logic        dec_double_ff;
	logic        expect_ext_ff;
	logic        dec_byte_ff;
	logic [3:0]  src_reg;
	logic [3:0]  dst_reg;
	logic [3:0]  bit_pos;
	logic        bit_ind;
	logic [15:0] literal;
	logic        acc_sel;
	logic [3:0]  base_reg;
	logic [2:0]  src_mode;
	logic [2:0]  dst_mode;
	logic        dst_valid;
	logic [12:0] file_addr;
	logic        to_w0;
	logic [1:0]  mult_pair;
	logic [3:0]  x_pf;
	logic [3:0]  y_pf;
	logic [1:0]  x_dst;
	logic [1:0]  y_dst;
	logic [1:0]  wb_target;
	logic [3:0]  sh_reg;
	logic        sh_ind;
	logic [22:0] prog_addr;
	logic [1:0]  tbl_mode;
	int          bad_count = 0;
	int          n_tests   = 0;

	iwd_fetch_model i_fetch (.clk(clk), .fetch_valid(fetch_valid), .fetch_word(fetch_word));

	iwd_decoder i_dut (.clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .dec_valid_ff(dec_valid_ff), .dec_cat_ff(dec_cat_ff),
		.dec_opcode_ff(dec_opcode_ff), .dec_nop_ff(dec_nop_ff), .dec_double_ff(dec_double_ff),
		.expect_ext_ff(expect_ext_ff), .dec_byte_ff(dec_byte_ff),
		.base_source_register_ff(base_reg), .second_source_register_ff(src_reg),
		.src_mode_ff(src_mode), .result_destination_register_ff(dst_reg),
		.dst_mode_ff(dst_mode), .dst_valid_ff(dst_valid),
		.file_addr_ff(file_addr), .to_working_register_zero_ff(to_w0), .bit_pos_ff(bit_pos),
		.bit_indirect_ff(bit_ind), .literal_ff(literal), .acc_sel_ff(acc_sel),
		.mult_pair_ff(mult_pair), .x_prefetch_ff(x_pf), .y_prefetch_ff(y_pf),
		.x_dest_ff(x_dst), .y_dest_ff(y_dst), .accumulator_writeback_target_ff(wb_target),
		.shift_amount_register_ff(sh_reg), .shift_indirect_ff(sh_ind),
		.prog_addr_ff(prog_addr), .table_mode_ff(tbl_mode));

	always #10 clk = ~clk;

	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Category and fields of one single word, checked the cycle it shows.
	task automatic check_single(input logic [23:0] w, input iwd_cat_e cat);
		check_val("valid", 24'h000001, dec_valid_ff);
		check_val("category", cat, dec_cat_ff);
		check_val("opcode", w[23:16], dec_opcode_ff);
		if (cat == IWD_CAT_WORD) begin
			check_val("source", w[IWD_SRC_REG_LSB +: 4], src_reg);
			check_val("dest", w[IWD_DST_REG_LSB +: 4], dst_reg);
			check_val("base", w[IWD_BASE_LSB +: 4], base_reg);
			check_val("src mode", w[IWD_SRC_MODE_LSB +: 3], src_mode);
			check_val("dst mode", w[IWD_DST_MODE_LSB +: 3], dst_mode);
		end
		if (cat == IWD_CAT_BIT) begin
			check_val("bit pos", w[IWD_BITSEL_LSB +: 4], bit_pos);
			check_val("bit ind", w[IWD_BITIND_BIT], bit_ind);
		end
		if (cat == IWD_CAT_DSP) begin
			check_val("acc", w[IWD_ACC_BIT], acc_sel);
		end
	endtask : check_single

	// Every category, words back to back so each is judged while the next is taken.
	task automatic t_categories();
		logic [7:0] ops [6] = '{8'h05, 8'h25, 8'h45, 8'hA5, 8'hC5, 8'h90};
		iwd_cat_e cats [6] = '{IWD_CAT_CONTROL, IWD_CAT_LITERAL, IWD_CAT_WORD, IWD_CAT_BIT,
			IWD_CAT_DSP, IWD_CAT_CONTROL};
		for (int i = 0; i < 6; i++) begin
			i_fetch.send({ops[i], 16'h5A93 ^ 16'(i * 16'h1111)});
			#1;
			if (i > 0) begin
				check_single({ops[i-1], 16'h5A93 ^ 16'((i - 1) * 16'h1111)}, cats[i-1]);
			end
		end
		i_fetch.idle();
		#1;
		check_single({ops[5], 16'h5A93 ^ 16'(5 * 16'h1111)}, cats[5]);
	endtask : t_categories

	// Each pair opcode, with zero, one and two idle cycles between its halves.
	task automatic t_double();
		logic [7:0] ops [3] = '{IWD_OPC_DBL0, IWD_OPC_DBL1, IWD_OPC_DBL2};
		logic [23:0] w1;
		for (int k = 0; k < 3; k++) begin
			w1 = {ops[k], 16'h1234 + 16'(k)};
			i_fetch.send(w1);
			repeat (k) i_fetch.idle();
			i_fetch.send(24'h00BEEF);
			#1;
			check_val("waiting", 24'h000001, expect_ext_ff);
			check_val("early valid", 24'h000000, dec_valid_ff);
			i_fetch.idle();
			#1;
			check_val("pair valid", 24'h000001, dec_valid_ff);
			check_val("pair flag", 24'h000001, dec_double_ff);
			check_val("pair opcode", ops[k], dec_opcode_ff);
			check_val("pair literal", w1[15:0], literal);
			check_val("pair address", {7'h6F, w1[15:0]}, prog_addr);
			check_val("released", 24'h000000, expect_ext_ff);
		end
	endtask : t_double

	// One word followed by an idle cycle; returns once its decode shows.
	task automatic decode_one(input logic [23:0] w);
		i_fetch.send(w);
		i_fetch.idle();
		#1;
	endtask : decode_one

	// Operand fields of every category except bit, one word at a time.
	task automatic t_fields();
		decode_one(24'hB50ABC);
		check_val("file addr", 24'h000ABC, file_addr);
		check_val("to w0", 24'h000001, to_w0);
		decode_one(24'h2C5673);
		check_val("move lit", 24'h00C567, literal);
		check_val("move dest", 24'h000003, dst_reg);
		check_val("move dvalid", 24'h000001, dst_valid);
		decode_one(24'h358580);
		check_val("arith base", 24'h00000B, base_reg);
		check_val("arith lit", 24'h000058, literal);
		check_val("same dest", 24'h000000, dst_valid);
		decode_one(24'h358500);
		check_val("other dest", 24'h000001, dst_valid);
		check_val("arith dest", 24'h00000A, dst_reg);
		decode_one(24'hC3A5A5);
		check_val("mac acc", 24'h000001, acc_sel);
		check_val("mac pair", 24'h000003, mult_pair);
		check_val("x prefetch", 24'h000006, x_pf);
		check_val("y prefetch", 24'h000009, y_pf);
		check_val("x dest", 24'h000002, x_dst);
		check_val("y dest", 24'h000001, y_dst);
		check_val("write back", 24'h000001, wb_target);
		decode_one(24'hCA2357);
		check_val("shift ind", 24'h000001, sh_ind);
		check_val("shift reg", 24'h000006, sh_reg);
		check_val("dsp operand", 24'h000007, src_reg);
		check_val("dsp mode", 24'h000005, src_mode);
		decode_one(24'h05ABCD);
		check_val("prog addr", 24'h00ABCD, prog_addr);
		decode_one(24'hBA4321);
		check_val("table mode", 24'h000001, tbl_mode);
	endtask : t_fields

	// A zero top byte that follows nothing, then one that follows a dropped pair.
	task automatic t_nop_and_drop();
		i_fetch.send(24'h001357);
		i_fetch.send({IWD_OPC_DBL1, 16'h0042});
		#1;
		check_val("nop", 24'h000001, dec_nop_ff);
		check_val("nop single", 24'h000000, dec_double_ff);
		i_fetch.send(24'h450001);
		i_fetch.send(24'h000001);
		#1;
		check_val("dropped", 24'h000000, dec_valid_ff);
		check_val("abandoned", 24'h000000, expect_ext_ff);
		i_fetch.idle();
		#1;
		check_val("later nop", 24'h000001, dec_nop_ff);
		check_val("not pair", 24'h000000, dec_double_ff);
	endtask : t_nop_and_drop

	// Reset while a pair waits must forget the first word.
	task automatic t_reset_mid();
		i_fetch.send({IWD_OPC_DBL2, 16'h0F0F});
		i_fetch.idle();
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		#1;
		check_val("reset wait", 24'h000000, expect_ext_ff);
		check_val("reset cat", IWD_CAT_CONTROL, dec_cat_ff);
		i_fetch.send(24'h000000);
		i_fetch.idle();
		#1;
		check_val("reset nop", 24'h000001, dec_nop_ff);
	endtask : t_reset_mid

	initial begin
		clk   = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_categories();
		t_double();
		t_fields();
		t_nop_and_drop();
		t_reset_mid();
		report_and_stop();
	end

	// The tests need well under a hundred cycles.
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule : instruction_word_decoder_tb_top

// ==== bench/iwd_decoder_sva.sv ====
// Concurrent checks on the port behaviour of the instruction word decoder.
`timescale 1ns/10ps
module iwd_decoder_sva
	import iwd_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_b,
	// Fetch side
	input wire logic              fetch_valid,
	input wire logic [23:0]       fetch_word,
	// Decoded outputs
	input wire logic              dec_valid_ff,
	input var  iwd_pkg::iwd_cat_e dec_cat_ff,
	input wire logic [7:0]        dec_opcode_ff,
	input wire logic              dec_nop_ff,
	input wire logic              dec_double_ff,
	input wire logic              expect_ext_ff,
	input wire logic              dec_byte_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic is_dbl;
	logic is_zero;
	assign is_dbl  = fetch_word[23:16] inside {IWD_OPC_DBL0, IWD_OPC_DBL1, IWD_OPC_DBL2};
	assign is_zero = fetch_word[23:16] == IWD_EXT_TAG;

	sequence s_first_word;
		fetch_valid && !expect_ext_ff && is_dbl;
	endsequence
	sequence s_ext_word;
		fetch_valid && expect_ext_ff && is_zero;
	endsequence

	wait_first_a: assert property (s_first_word |=> expect_ext_ff && !dec_valid_ff)
		else $error("first word of a pair not held for its extension");
	dbl_done_a: assert property (s_ext_word |=> dec_valid_ff && dec_double_ff && !expect_ext_ff)
		else $error("pair not completed on its second word");
	dbl_opcode_a: assert property (s_first_word ##1 s_ext_word |=>
		dec_opcode_ff == $past(fetch_word[23:16], 2))
		else $error("pair opcode not taken from the first word");
	hold_wait_a: assert property (expect_ext_ff && !fetch_valid |=> expect_ext_ff && !dec_valid_ff)
		else $error("pending pair lost during an idle cycle");
	drop_ext_a: assert property (fetch_valid && expect_ext_ff && !is_zero |=>
		!dec_valid_ff && !expect_ext_ff)
		else $error("bad extension word not dropped");
	lone_nop_a: assert property (fetch_valid && !expect_ext_ff && is_zero |=>
		dec_valid_ff && dec_nop_ff && !dec_double_ff)
		else $error("lone extension word not decoded as no-operation");
	single_op_a: assert property (fetch_valid && !expect_ext_ff && !is_dbl && !is_zero |=>
		dec_valid_ff && dec_opcode_ff == $past(fetch_word[23:16])
		&& dec_byte_ff == $past(fetch_word[14]))
		else $error("single word opcode or byte flag wrong");
	cat_onehot_a: assert property (dec_valid_ff |-> $onehot(dec_cat_ff))
		else $error("category is not one of the five");
	valid_cause_a: assert property (dec_valid_ff |-> $past(fetch_valid))
		else $error("decode without a fetched word");
endmodule : iwd_decoder_sva

bind iwd_decoder iwd_decoder_sva i_sva (.clk, .rst_b, .fetch_valid, .fetch_word, .dec_valid_ff,
	.dec_cat_ff, .dec_opcode_ff, .dec_nop_ff, .dec_double_ff, .expect_ext_ff, .dec_byte_ff);

// ==== bench/iwd_fetch_model.sv ====
// Behavioural program fetch stage that presents words to the decoder.
`timescale 1ns/10ps
module iwd_fetch_model (
	// Clock
	input  wire logic        clk,
	// Fetch side
	output logic             fetch_valid,
	output logic      [23:0] fetch_word
);
	initial begin
		fetch_valid = 1'b0;
		fetch_word  = 24'h000000;
	end

	// One word for one cycle; a pair is two calls, first word first.
	task automatic send(input logic [23:0] w);
		@(posedge clk);
		fetch_valid <= 1'b1;
		fetch_word  <= w;
	endtask : send

	// The word lines toggle when idle so a stale word is never read as fresh.
	task automatic idle();
		@(posedge clk);
		fetch_valid <= 1'b0;
		fetch_word  <= ~fetch_word;
	endtask : idle
endmodule : iwd_fetch_model

// ==== rtl/iwd_decoder.sv ====
// Instruction word decoder: classifies fetched words and registers their operand fields.
//
// Contract
// - 24-bit word, 8-bit opcode selects type.
// - Exactly three instructions span two words.
// - Double-word operands come from combined 48 bits.
// - Second word has zero top byte.
// - Lone second word executes as no-operation.
// - Classify into five instruction categories.
// - Word ops decode base, source, destination operands.
// - File ops decode address and destination select.
// - Bit ops: operand plus literal or indirect bit.
// - Literal moves load a working register; no file register address is decoded.
// - Literal arithmetic: base, literal, optional destination.
// - MAC decodes accumulator, multiplicands, prefetches, write-back.
// - Other DSP: accumulator, operand, shift amount.
// - Control: program address and table mode.
// - Double-word instructions take two cycles.
// - Write-back is W13 or post-incremented location.
`timescale 1ns/10ps
module iwd_decoder (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	// Fetch side
	input  wire logic                    fetch_valid,
	input  wire logic [23:0]             fetch_word,
	// Decoded outputs
	output logic                         dec_valid_ff,
	output iwd_pkg::iwd_cat_e            dec_cat_ff,
	output logic      [7:0]              dec_opcode_ff,
	output logic                         dec_nop_ff,
	output logic                         dec_double_ff,
	output logic                         expect_ext_ff,
	output logic                         dec_byte_ff,
	output logic      [3:0]              base_source_register_ff,
	output logic      [3:0]              second_source_register_ff,
	output logic      [2:0]              src_mode_ff,
	output logic      [3:0]              result_destination_register_ff,
	output logic      [2:0]              dst_mode_ff,
	output logic                         dst_valid_ff,
	output logic      [12:0]             file_addr_ff,
	output logic                         to_working_register_zero_ff,
	output logic      [3:0]              bit_pos_ff,
	output logic                         bit_indirect_ff,
	output logic      [15:0]             literal_ff,
	output logic                         acc_sel_ff,
	output logic      [1:0]              mult_pair_ff,
	output logic      [3:0]              x_prefetch_ff,
	output logic      [3:0]              y_prefetch_ff,
	output logic      [1:0]              x_dest_ff,
	output logic      [1:0]              y_dest_ff,
	output logic      [1:0]              accumulator_writeback_target_ff,
	output logic      [3:0]              shift_amount_register_ff,
	output logic                         shift_indirect_ff,
	output logic      [22:0]             prog_addr_ff,
	output logic      [1:0]              table_mode_ff
);
	import iwd_pkg::*;

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic is_double(input logic [7:0] v);
		is_double = (v == IWD_OPC_DBL0) || (v == IWD_OPC_DBL1) || (v == IWD_OPC_DBL2);
	endfunction : is_double

	logic [7:0]  f_opc;
	logic [3:0]  f_base;
	logic [3:0]  f_src;
	logic [2:0]  f_smode;
	logic [3:0]  f_dst;
	logic [2:0]  f_dmode;
	logic [15:0] f_lit;

	iwd_field_split u_split (
		.word     (fetch_word),
		.opcode   (f_opc),
		.base_reg (f_base),
		.src_reg  (f_src),
		.src_mode (f_smode),
		.dst_reg  (f_dst),
		.dst_mode (f_dmode),
		.low_lit  (f_lit)
	);

	// The first word of a double-word instruction is held until the next fetched word, which completes or drops it.
	iwd_state_e  state_ff;
	iwd_state_e  nxt_state;
	logic [23:0] first_word_ff;
	logic [23:0] nxt_first_word;

	always_comb begin
		nxt_state      = state_ff;
		nxt_first_word = first_word_ff;
		case (state_ff)
			IWD_ST_SINGLE: begin
				if (fetch_valid && is_double(f_opc)) begin
					nxt_state      = IWD_ST_EXT;
					nxt_first_word = fetch_word;
				end
			end
			IWD_ST_EXT: begin
				if (fetch_valid) begin
					nxt_state = IWD_ST_SINGLE;
				end
			end
			default: begin
				nxt_state = IWD_ST_SINGLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff      <= IWD_ST_SINGLE;
			first_word_ff <= 24'h000000;
		end else begin
			state_ff      <= nxt_state;
			first_word_ff <= nxt_first_word;
		end
	end

	// Decoded field computation.
	logic        n_valid;
	iwd_cat_e    n_cat;
	logic        n_nop;
	logic        n_double;
	logic        n_byte;
	logic [3:0]  n_base;
	logic [3:0]  n_src;
	logic [2:0]  n_smode;
	logic [3:0]  n_dst;
	logic [2:0]  n_dmode;
	logic        n_dvalid;
	logic [12:0] n_file;
	logic        n_wreg0;
	logic [3:0]  n_bit;
	logic        n_bitind;
	logic [15:0] n_lit;
	logic        n_acc;
	logic [1:0]  n_pair;
	logic [3:0]  n_xpf;
	logic [3:0]  n_ypf;
	logic [1:0]  n_xd;
	logic [1:0]  n_yd;
	logic [1:0]  n_awb;
	logic [3:0]  n_shreg;
	logic        n_shind;
	logic [22:0] n_pma;
	logic [1:0]  n_tbl;
	logic [47:0] dbl;
	logic [7:0]  opc;

	always_comb begin
		dbl      = {first_word_ff, fetch_word};
		opc      = f_opc;
		n_valid  = fetch_valid;
		n_cat    = IWD_CAT_CONTROL;
		n_nop    = 1'b0;
		n_double = 1'b0;
		n_byte   = fetch_word[14];
		n_base   = 4'h0;
		n_src    = 4'h0;
		n_smode  = 3'h0;
		n_dst    = 4'h0;
		n_dmode  = 3'h0;
		n_dvalid = 1'b0;
		n_file   = 13'h0000;
		n_wreg0  = 1'b0;
		n_bit    = 4'h0;
		n_bitind = 1'b0;
		n_lit    = 16'h0000;
		n_acc    = 1'b0;
		n_pair   = 2'h0;
		n_xpf    = 4'h0;
		n_ypf    = 4'h0;
		n_xd     = 2'h0;
		n_yd     = 2'h0;
		n_awb    = 2'h0;
		n_shreg  = 4'h0;
		n_shind  = 1'b0;
		n_pma    = 23'h000000;
		n_tbl    = 2'h0;
		if (state_ff == IWD_ST_EXT) begin
			// Operands of the pair come from both words; only a zero-tagged word completes it.
			opc      = first_word_ff[IWD_OPC_LSB +: IWD_OPC_W];
			n_double = 1'b1;
			n_valid  = fetch_valid && (fetch_word[IWD_OPC_LSB +: IWD_OPC_W] == IWD_EXT_TAG);
			n_pma    = {dbl[IWD_PMA_W-IWD_LIT_W-1:0], dbl[IWD_WORD_W +: IWD_LIT_W]};
			n_lit    = dbl[IWD_DBL_W-IWD_OPC_W-1 -: IWD_LIT_W];
			n_src    = fetch_word[IWD_SRC_REG_LSB +: IWD_WORKING_REGISTER_ZERO_W];
		end else if (opc == IWD_OPC_NOP) begin
			n_nop = 1'b1;
		end else if (is_double(opc)) begin
			n_valid = 1'b0;
		end else if (in_range(opc, IWD_OPC_NOP, IWD_OPC_CTL_HI)) begin
			n_cat = IWD_CAT_CONTROL;
			n_pma = {7'h00, f_lit};
		end else if (in_range(opc, IWD_OPC_TBL_LO, IWD_OPC_TBL_HI)) begin
			n_cat   = IWD_CAT_CONTROL;
			n_tbl   = fetch_word[IWD_TBLMODE_LSB +: 2];
			n_src   = f_src;
			n_smode = f_smode;
			n_dst   = f_dst;
			n_dmode = f_dmode;
		end else if (in_range(opc, IWD_OPC_LIT_LO, IWD_OPC_LIT_HI)) begin
			n_cat = IWD_CAT_LITERAL;
			if (opc[4]) begin
				n_lit = {6'h00, fetch_word[13:4]};
				n_base = f_base;
				n_dst  = f_dst;
				n_dmode = f_dmode;
				n_dvalid = (f_dst != f_base) || (f_dmode != 3'h0);
			end else begin
				n_lit = fetch_word[19:4];
				n_dst = f_src;
				n_dvalid = 1'b1;
			end
		end else if (in_range(opc, IWD_OPC_WB_LO, IWD_OPC_WB_HI)) begin
			n_cat    = IWD_CAT_WORD;
			n_base   = f_base;
			n_src    = f_src;
			n_smode  = f_smode;
			n_dst    = f_dst;
			n_dmode  = f_dmode;
			n_dvalid = 1'b1;
		end else if (in_range(opc, IWD_OPC_BIT_LO, IWD_OPC_BIT_HI)) begin
			n_cat    = IWD_CAT_BIT;
			n_bitind = fetch_word[IWD_BITIND_BIT];
			n_bit    = fetch_word[IWD_BITSEL_LSB +: 4];
			n_base   = f_base;
			n_src    = f_src;
			n_smode  = f_smode;
			n_file   = fetch_word[IWD_FILE_W:1];
		end else if (in_range(opc, IWD_OPC_FILE_LO, IWD_OPC_FILE_HI)) begin
			n_cat   = IWD_CAT_WORD;
			n_file  = fetch_word[IWD_FILE_W-1:0];
			n_wreg0 = !fetch_word[IWD_DIR_BIT];
		end else if (in_range(opc, IWD_OPC_DSP_LO, IWD_OPC_DSP_HI)) begin
			n_cat = IWD_CAT_DSP;
			n_acc = fetch_word[IWD_ACC_BIT];
			if (opc <= IWD_OPC_MAC_HI) begin
				n_pair = fetch_word[IWD_WM_LSB +: 2];
				n_xpf  = fetch_word[IWD_XPF_LSB +: 4];
				n_ypf  = fetch_word[IWD_YPF_LSB +: 4];
				n_xd   = fetch_word[IWD_XDST_LSB +: 2];
				n_yd   = fetch_word[IWD_YDST_LSB +: 2];
				n_awb  = fetch_word[IWD_AWB_LSB +: 2];
			end else begin
				n_src    = f_src;
				n_smode  = f_smode;
				n_shind  = fetch_word[IWD_SHIND_BIT];
				// The shift register number shares the literal field; the indirect bit picks one.
				n_shreg  = fetch_word[IWD_SHLIT_LSB +: IWD_WORKING_REGISTER_ZERO_W];
				n_lit    = {10'h000, fetch_word[IWD_SHLIT_LSB +: 6]};
			end
		end else begin
			// Unassigned opcodes fall through as control with no operands.
			n_cat = IWD_CAT_CONTROL;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dec_valid_ff                    <= 1'b0;
			dec_cat_ff                      <= IWD_CAT_CONTROL;
			dec_opcode_ff                   <= 8'h00;
			dec_nop_ff                      <= 1'b0;
			dec_double_ff                   <= 1'b0;
			expect_ext_ff                   <= 1'b0;
			dec_byte_ff                     <= 1'b0;
			base_source_register_ff         <= 4'h0;
			second_source_register_ff       <= 4'h0;
			src_mode_ff                     <= 3'h0;
			result_destination_register_ff  <= 4'h0;
			dst_mode_ff                     <= 3'h0;
			dst_valid_ff                    <= 1'b0;
			file_addr_ff                    <= 13'h0000;
			to_working_register_zero_ff     <= 1'b0;
			bit_pos_ff                      <= 4'h0;
			bit_indirect_ff                 <= 1'b0;
			literal_ff                      <= 16'h0000;
			acc_sel_ff                      <= 1'b0;
			mult_pair_ff                    <= 2'h0;
			x_prefetch_ff                   <= 4'h0;
			y_prefetch_ff                   <= 4'h0;
			x_dest_ff                       <= 2'h0;
			y_dest_ff                       <= 2'h0;
			accumulator_writeback_target_ff <= 2'h0;
			shift_amount_register_ff        <= 4'h0;
			shift_indirect_ff               <= 1'b0;
			prog_addr_ff                    <= 23'h000000;
			table_mode_ff                   <= 2'h0;
		end else begin
			dec_valid_ff                    <= n_valid;
			dec_cat_ff                      <= n_cat;
			dec_opcode_ff                   <= opc;
			dec_nop_ff                      <= n_nop;
			dec_double_ff                   <= n_double;
			expect_ext_ff                   <= (nxt_state == IWD_ST_EXT);
			dec_byte_ff                     <= n_byte;
			base_source_register_ff         <= n_base;
			second_source_register_ff       <= n_src;
			src_mode_ff                     <= n_smode;
			result_destination_register_ff  <= n_dst;
			dst_mode_ff                     <= n_dmode;
			dst_valid_ff                    <= n_dvalid;
			file_addr_ff                    <= n_file;
			to_working_register_zero_ff     <= n_wreg0;
			bit_pos_ff                      <= n_bit;
			bit_indirect_ff                 <= n_bitind;
			literal_ff                      <= n_lit;
			acc_sel_ff                      <= n_acc;
			mult_pair_ff                    <= n_pair;
			x_prefetch_ff                   <= n_xpf;
			y_prefetch_ff                   <= n_ypf;
			x_dest_ff                       <= n_xd;
			y_dest_ff                       <= n_yd;
			accumulator_writeback_target_ff <= n_awb;
			shift_amount_register_ff        <= n_shreg;
			shift_indirect_ff               <= n_shind;
			prog_addr_ff                    <= n_pma;
			table_mode_ff                   <= n_tbl;
		end
	end

endmodule : iwd_decoder

// ==== rtl/iwd_field_split.sv ====
// Combinational splitter of one instruction word into its raw operand fields.
`timescale 1ns/10ps
module iwd_field_split (
	// Word in
	input  wire logic [23:0] word,
	// Raw fields
	output logic      [7:0]  opcode,
	output logic      [3:0]  base_reg,
	output logic      [3:0]  src_reg,
	output logic      [2:0]  src_mode,
	output logic      [3:0]  dst_reg,
	output logic      [2:0]  dst_mode,
	output logic      [15:0] low_lit
);
	import iwd_pkg::*;

	always_comb begin
		opcode   = word[IWD_OPC_LSB +: IWD_OPC_W];
		base_reg = word[IWD_BASE_LSB +: IWD_WORKING_REGISTER_ZERO_W];
		src_reg  = word[IWD_SRC_REG_LSB +: IWD_WORKING_REGISTER_ZERO_W];
		src_mode = word[IWD_SRC_MODE_LSB +: IWD_MODE_W];
		dst_reg  = word[IWD_DST_REG_LSB +: IWD_WORKING_REGISTER_ZERO_W];
		dst_mode = word[IWD_DST_MODE_LSB +: IWD_MODE_W];
		low_lit  = word[IWD_LIT_W-1:0];
	end

endmodule : iwd_field_split

// ==== rtl/iwd_pkg.sv ====
// Package of opcode field layouts, categories and constants for the instruction word decoder.
package iwd_pkg;

	localparam int unsigned IWD_WORD_W      = 24;
	localparam int unsigned IWD_OPC_W       = 8;
	localparam int unsigned IWD_OPC_LSB     = 16;
	localparam int unsigned IWD_DBL_W       = 48;
	localparam int unsigned IWD_WORKING_REGISTER_ZERO_W      = 4;
	localparam int unsigned IWD_MODE_W      = 3;
	localparam int unsigned IWD_FILE_W      = 13;
	localparam int unsigned IWD_LIT_W       = 16;
	localparam int unsigned IWD_PMA_W       = 23;
	localparam int unsigned IWD_DBL_CYCLES  = 2;

	// Field positions within a single instruction word.
	localparam int unsigned IWD_DST_MODE_LSB = 11;
	localparam int unsigned IWD_DST_REG_LSB  = 7;
	localparam int unsigned IWD_BASE_LSB     = 15;
	localparam int unsigned IWD_SRC_MODE_LSB = 4;
	localparam int unsigned IWD_SRC_REG_LSB  = 0;
	localparam int unsigned IWD_DIR_BIT      = 13;
	localparam int unsigned IWD_BITSEL_LSB   = 12;
	localparam int unsigned IWD_BITIND_BIT   = 11;
	localparam int unsigned IWD_ACC_BIT      = 15;
	localparam int unsigned IWD_WM_LSB       = 16;
	localparam int unsigned IWD_XPF_LSB      = 6;
	localparam int unsigned IWD_YPF_LSB      = 2;
	localparam int unsigned IWD_XDST_LSB     = 12;
	localparam int unsigned IWD_YDST_LSB     = 10;
	localparam int unsigned IWD_AWB_LSB      = 0;
	localparam int unsigned IWD_SHLIT_LSB    = 7;
	localparam int unsigned IWD_SHIND_BIT    = 13;
	localparam int unsigned IWD_TBLMODE_LSB  = 14;

	// Opcode ranges bounding each category (upper opcode bits).
	localparam logic [7:0] IWD_OPC_NOP     = 8'h00;
	localparam logic [7:0] IWD_OPC_CTL_HI  = 8'h0F;
	localparam logic [7:0] IWD_OPC_LIT_LO  = 8'h20;
	localparam logic [7:0] IWD_OPC_LIT_HI  = 8'h3F;
	localparam logic [7:0] IWD_OPC_WB_LO   = 8'h40;
	localparam logic [7:0] IWD_OPC_WB_HI   = 8'h7F;
	localparam logic [7:0] IWD_OPC_BIT_LO  = 8'hA0;
	localparam logic [7:0] IWD_OPC_BIT_HI  = 8'hAF;
	localparam logic [7:0] IWD_OPC_DSP_LO  = 8'hC0;
	localparam logic [7:0] IWD_OPC_DSP_HI  = 8'hCF;
	localparam logic [7:0] IWD_OPC_FILE_LO = 8'hB0;
	localparam logic [7:0] IWD_OPC_FILE_HI = 8'hBF;
	localparam logic [7:0] IWD_OPC_MAC_HI  = 8'hC7;
	localparam logic [7:0] IWD_OPC_TBL_LO  = 8'hBA;
	localparam logic [7:0] IWD_OPC_TBL_HI  = 8'hBB;

	// The three opcodes whose instructions span two words.
	localparam logic [7:0] IWD_OPC_DBL0 = 8'h02;
	localparam logic [7:0] IWD_OPC_DBL1 = 8'h04;
	localparam logic [7:0] IWD_OPC_DBL2 = 8'h0B;

	localparam logic [7:0] IWD_EXT_TAG = 8'h00;

	typedef enum logic [4:0] {
		IWD_CAT_WORD    = 5'h01,
		IWD_CAT_BIT     = 5'h02,
		IWD_CAT_LITERAL = 5'h04,
		IWD_CAT_DSP     = 5'h08,
		IWD_CAT_CONTROL = 5'h10
	} iwd_cat_e;

	typedef enum logic [1:0] {
		IWD_ST_SINGLE = 2'h1,
		IWD_ST_EXT    = 2'h2
	} iwd_state_e;

endpackage : iwd_pkg
